// ---- core/fsps_sequencer.v ----
// flash self-program sequencer: control register, unlock key, table pointer,
// table latch, 64 holding registers and self-timed erase/write with core stall
// assumes an AHB-Lite master with single word transfers and an external flash
// array that accepts a block erase or 64-byte chunk program request
//
// Summary of operation
// - erase needs write-enable (bit 2) and erase-select (bit 4) both set
// - key port must get 55h then 0AAh before start may begin a cycle
// - start with erase selected begins block erase; core stalled throughout
// - programming only in 64-byte chunks, never single bytes or words
// - 64 byte holding registers, each table write loads one from latch
// - table write is short: updates holding register only, no array program
// - start after loading begins long write; instruction execution halts
// - internal timer sets and ends each erase or write cycle
// - holding registers keep contents after write; software overwrites them
// - write: write-enable without erase, unlock, start; chunk programmed
// - block taken from pointer bits 21..10, lower bits ignored
// - start only settable by software, cleared by hardware at completion
// - erase-select cleared by hardware when erase completes
// - abort flag set on reset mid-cycle or improper start attempt
//
// The AHB-Lite register port and the register addresses were left to the implementer.

`include "fsps_consts.vh"

module fsps_sequencer #(
  parameter ERASE_CYCLES = `FSPS_ERASE_CYC,
  parameter WRITE_CYCLES = `FSPS_WRITE_CYC,
  parameter HOLD_DEPTH   = 64
) (
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // core side
  output wire        core_stall,
  // flash array side
  output reg         flash_erase_req,
  output reg         flash_prog_req,
  output reg  [11:0] flash_block,
  output reg  [5:0]  flash_chunk,
  output wire [511:0] flash_prog_data,
  input  wire [7:0]  flash_rd_data,
  output wire [21:0] flash_rd_addr
);

  localparam ST_IDLE  = 3'b001;
  localparam ST_ERASE = 3'b010;
  localparam ST_WRITE = 3'b100;

  reg  [2:0]  state;
  reg         start_bit;
  reg         write_enable_bit_bit;
  reg         erase_sel;
  reg         abort_flag;
  reg  [1:0]  unlock_stage;
  reg  [21:0] table_pointer;
  reg  [7:0]  table_latch;
  reg  [7:0]  hold_mem [0:HOLD_DEPTH-1];
  reg  [31:0] cyc_cnt;
  reg  [31:0] rdata;
  reg         rd_pend;
  reg         ap_wr;
  reg  [7:0]  ap_addr;
  reg  [31:0] next_cyc_cnt;
  reg         live_mark;

  wire busy = (state != ST_IDLE);

  // address phase capture
  wire ap_valid = hsel & hready & htrans[1];

  // pointer update for table operations
  function [21:0] tp_step;
    input [21:0] tp;
    input [1:0]  mode;
    begin
      case (mode)
        `FSPS_TM_POSTINC: tp_step = {tp[21], tp[20:0] + 21'h000001};
        `FSPS_TM_PREINC:  tp_step = {tp[21], tp[20:0] + 21'h000001};
        `FSPS_TM_POSTDEC: tp_step = {tp[21], tp[20:0] - 21'h000001};
        default:          tp_step = tp;
      endcase
    end
  endfunction

  // bus never waits; stall is carried on core_stall instead
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata;
  assign core_stall = busy;
  assign flash_rd_addr = table_pointer;

  genvar gi;
  generate
    for (gi = 0; gi < HOLD_DEPTH; gi = gi + 1) begin : g_pack
      assign flash_prog_data[gi*8 +: 8] = hold_mem[gi];
    end
  endgenerate

  wire        dw     = ap_wr;
  wire [7:0]  wd8    = hwdata[7:0];
  // one register slot hit; shared by the write strobes and the read mux
  function reg_hit;
    input [7:0] a;
    input [7:0] off;
    begin
      reg_hit = (a == off);
    end
  endfunction

  // timer load for the cycle about to start
  function [31:0] cycle_len;
    input erase;
    begin
      cycle_len = erase ? ERASE_CYCLES : WRITE_CYCLES;
    end
  endfunction

  wire        w_ctrl = dw & reg_hit(ap_addr, `FSPS_OFF_CTRL);
  wire        w_key  = dw & reg_hit(ap_addr, `FSPS_OFF_KEY);
  wire        w_tptr = dw & reg_hit(ap_addr, `FSPS_OFF_TPTR);
  wire        w_tlat = dw & reg_hit(ap_addr, `FSPS_OFF_TLAT);
  wire        w_tcmd = dw & reg_hit(ap_addr, `FSPS_OFF_TCMD);
  wire [1:0]  tmode  = hwdata[`FSPS_TMODE_HI:`FSPS_TMODE_LO];
  wire        start_try = w_ctrl & wd8[`FSPS_BIT_START] & ~busy;
  // start is honoured only right after the key pair while enabled
  wire        start_ok = start_try & (unlock_stage == 2'h2) & write_enable_bit_bit
                         & wd8[`FSPS_BIT_WRITE_ENABLE_BIT];
  wire        go_erase = start_ok & wd8[`FSPS_BIT_ERASE];
  wire        tw_do  = w_tcmd & hwdata[`FSPS_BIT_TWR] & ~busy;
  wire        tr_do  = w_tcmd & hwdata[`FSPS_BIT_TRD] & ~busy;
  // pre-increment writes land on the stepped pointer in the same cycle,
  // so a fill from first-minus-one starts at holding register zero
  wire [21:0] tw_ptr = (tmode == `FSPS_TM_PREINC) ? tp_step(table_pointer, tmode)
                                                   : table_pointer;
  // last busy cycle; the count is never reloaded while busy
  wire        done   = busy & (cyc_cnt == 32'h00000001);

  // a zero cycle length would hang busy forever; keep both above zero
  always @* begin
    next_cyc_cnt = cyc_cnt;
    if (start_ok) begin
      next_cyc_cnt = cycle_len(go_erase);
    end else if (busy && cyc_cnt != 32'h00000000) begin
      next_cyc_cnt = cyc_cnt - 32'h00000001;
    end
  end

  // bus address phase pipeline
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr   <= 1'b0;
      rd_pend <= 1'b0;
      ap_addr <= 8'h00;
    end else begin
      ap_wr   <= ap_valid & hwrite;
      rd_pend <= ap_valid & ~hwrite;
      if (ap_valid) begin
        ap_addr <= {haddr[7:2], 2'b00};
      end
    end
  end

  // read mux; the holding window reaches only the first 16 entries,
  // the rest are visible on the program data bus alone
  function [31:0] rd_word;
    input [7:0] a;
    reg   [7:0] wa;
    begin
      wa = {a[7:2], 2'b00};
      if (a[7:6] == 2'b01) begin
        rd_word = {24'h000000, hold_mem[a[7:2] - 6'h10]};
      end else if (reg_hit(wa, `FSPS_OFF_CTRL)) begin
        rd_word = {27'h0, erase_sel, abort_flag, write_enable_bit_bit, start_bit, 1'b0};
      end else if (reg_hit(wa, `FSPS_OFF_TPTR)) begin
        rd_word = {10'h000, table_pointer};
      end else if (reg_hit(wa, `FSPS_OFF_TLAT)) begin
        rd_word = {24'h000000, table_latch};
      end else if (reg_hit(wa, `FSPS_OFF_STAT)) begin
        rd_word = {27'h0, state, unlock_stage};
      end else begin
        // key port and unused slots read zero
        rd_word = 32'h00000000;
      end
    end
  endfunction

  // read data registered in the address phase for the next data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata <= 32'h00000000;
    end else if (ap_valid && !hwrite) begin
      rdata <= rd_word(haddr);
    end
  end

  // remembers a running cycle across reset; deliberately not reset, so a
  // reset that cuts a cycle short still leaves its trace behind
  always @(posedge hclk) begin
    if (hresetn) begin
      live_mark <= busy & ~done;
    end
  end

  // sequencer state and control bits
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state           <= ST_IDLE;
      start_bit       <= 1'b0;
      write_enable_bit_bit        <= 1'b0;
      erase_sel       <= 1'b0;
      abort_flag      <= 1'b0;
      unlock_stage    <= 2'h0;
      cyc_cnt         <= 32'h00000000;
      flash_erase_req <= 1'b0;
      flash_prog_req  <= 1'b0;
      flash_block     <= 12'h000;
      flash_chunk     <= 6'h00;
    end else begin
      cyc_cnt         <= next_cyc_cnt;
      flash_erase_req <= 1'b0;
      flash_prog_req  <= 1'b0;
      // any bus write breaks the key pair unless it continues it;
      // reads leave it alone so a status poll between keys is harmless
      if (w_key && wd8 == `FSPS_KEY1) begin
        unlock_stage <= 2'h1;
      end else if (w_key && wd8 == `FSPS_KEY2 && unlock_stage == 2'h1) begin
        unlock_stage <= 2'h2;
      end else if (dw) begin
        unlock_stage <= 2'h0;
      end
      // control writes are dropped while a cycle runs, so a stray write
      // cannot change the operation under way
      if (w_ctrl && !busy) begin
        write_enable_bit_bit  <= wd8[`FSPS_BIT_WRITE_ENABLE_BIT];
        erase_sel <= wd8[`FSPS_BIT_ERASE];
        if (!wd8[`FSPS_BIT_ABORT]) begin
          abort_flag <= 1'b0;
        end
      end
      // both sets come after the clear so that they win in one cycle
      if (start_try && !start_ok) begin
        abort_flag <= 1'b1;
      end
      if (live_mark && !busy) begin
        abort_flag <= 1'b1;
      end
      case (state)
        ST_IDLE: begin
          if (start_ok) begin
            start_bit   <= 1'b1;
            flash_block <= table_pointer[21:10];
            flash_chunk <= table_pointer[9:4] & 6'h3C;
            if (go_erase) begin
              state           <= ST_ERASE;
              flash_erase_req <= 1'b1;
            end else begin
              state          <= ST_WRITE;
              flash_prog_req <= 1'b1;
            end
          end
        end
        ST_ERASE: begin
          if (done) begin
            state     <= ST_IDLE;
            start_bit <= 1'b0;
            erase_sel <= 1'b0;
          end
        end
        ST_WRITE: begin
          if (done) begin
            state     <= ST_IDLE;
            start_bit <= 1'b0;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // table pointer, latch and table reads
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      table_pointer <= `FSPS_TPTR_RST;
      table_latch   <= 8'h00;
    end else begin
      if (w_tptr && !busy) begin
        table_pointer <= hwdata[21:0];
      end else if (tw_do || tr_do) begin
        table_pointer <= tp_step(table_pointer, tmode);
      end
      // the array is read straight from the pointer, no wait state
      if (w_tlat && !busy) begin
        table_latch <= wd8;
      end else if (tr_do) begin
        table_latch <= flash_rd_data;
      end
    end
  end

  // holding registers: not reset and never cleared by a write cycle
  always @(posedge hclk) begin
    if (tw_do)
      hold_mem[tw_ptr[5:0]] <= table_latch;
  end

endmodule // fsps_sequencer

// ---- core/fsps_consts.vh ----
// constants for the flash self-program sequencer
// assumes one 10 MHz clock; included by bare name
`ifndef FSPS_CONSTS_VH
`define FSPS_CONSTS_VH
// register byte offsets
`define FSPS_OFF_CTRL     8'h00
`define FSPS_OFF_KEY      8'h04
`define FSPS_OFF_TPTR     8'h08
`define FSPS_OFF_TLAT     8'h0C
`define FSPS_OFF_TCMD     8'h10
`define FSPS_OFF_STAT     8'h14
`define FSPS_OFF_HOLD     8'h40
// control register field positions
`define FSPS_BIT_START    1
`define FSPS_BIT_WRITE_ENABLE_BIT     2
`define FSPS_BIT_ABORT    3
`define FSPS_BIT_ERASE    4
// table command field positions
`define FSPS_BIT_TWR      0
`define FSPS_BIT_TRD      1
`define FSPS_TMODE_LO     2
`define FSPS_TMODE_HI     3
// table pointer modes
`define FSPS_TM_NONE      2'h0
`define FSPS_TM_POSTINC   2'h1
`define FSPS_TM_POSTDEC   2'h2
`define FSPS_TM_PREINC    2'h3
// unlock keys
`define FSPS_KEY1         8'h55
`define FSPS_KEY2         8'hAA
// reset values
`define FSPS_CTRL_RST     8'h00
`define FSPS_TPTR_RST     22'h000000
// timing: cycle times in microseconds, clock in MHz
`define FSPS_CLK_MHZ      10
`define FSPS_ERASE_US     2000
`define FSPS_WRITE_US     2000
`define FSPS_ERASE_CYC    (`FSPS_ERASE_US * `FSPS_CLK_MHZ)
`define FSPS_WRITE_CYC    (`FSPS_WRITE_US * `FSPS_CLK_MHZ)
`endif

// ---- bench/fsps_monitor.sv ----
// checker on the sequencer top ports: stall, request pulses, block capture
// assumes hclk rising edge and asynchronous active-low hresetn
module fsps_monitor #(
  parameter ERASE_CYCLES = 20,
  parameter WRITE_CYCLES = 20
) (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // sequencer outputs
  input wire logic        core_stall,
  input wire logic        flash_erase_req,
  input wire logic        flash_prog_req,
  input wire logic [11:0] flash_block,
  input wire logic [5:0]  flash_chunk,
  input wire logic [21:0] flash_rd_addr
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  int unsigned run_len;
  logic        was_erase;
  // length of the current stall run, and which kind started it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_len   <= 0;
      was_erase <= 1'b0;
    end else begin
      run_len <= core_stall ? run_len + 1 : 0;
      if (flash_erase_req || flash_prog_req) was_erase <= flash_erase_req;
    end
  end
  a_erase_pulse: assert property (flash_erase_req |=> !flash_erase_req)
    else $error("erase request longer than one cycle");
  a_erase_stall: assert property (flash_erase_req |-> core_stall)
    else $error("erase started without stall");
  a_prog_stall: assert property (flash_prog_req |-> core_stall ##1 core_stall)
    else $error("write started without stall");
  a_stall_cause: assert property ($rose(core_stall) |-> flash_erase_req || flash_prog_req)
    else $error("stall without a start");
  a_cycle_timer: assert property ($fell(core_stall) |->
    run_len == (was_erase ? ERASE_CYCLES : WRITE_CYCLES))
    else $error("cycle length wrong");
  a_erase_block: assert property (flash_erase_req |-> flash_block == flash_rd_addr[21:10])
    else $error("block not taken from pointer");
  a_block_held: assert property (core_stall && $past(core_stall) |-> $stable(flash_block))
    else $error("block moved during cycle");
  a_no_restart: assert property (core_stall && $past(core_stall) |->
    !(flash_erase_req || flash_prog_req))
    else $error("start accepted while busy");
  a_chunk_index: assert property (flash_prog_req |->
    flash_chunk == (flash_rd_addr[9:4] & 6'h3C))
    else $error("chunk index wrong");
  c_erase: cover property (flash_erase_req);
  c_prog: cover property (flash_prog_req);
  c_done: cover property ($fell(core_stall));
endmodule // fsps_monitor

bind fsps_sequencer fsps_monitor #(.ERASE_CYCLES(ERASE_CYCLES), .WRITE_CYCLES(WRITE_CYCLES))
  u_mon (.hclk, .hresetn, .core_stall, .flash_erase_req, .flash_prog_req, .flash_block,
         .flash_chunk, .flash_rd_addr);

// ---- bench/fsps_flash_model.sv ----
// behavioural flash array: read data from address, counts erase and write requests
// assumes one-cycle request pulses on hclk
module fsps_flash_model (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // array requests
  input wire logic        flash_erase_req,
  input wire logic        flash_prog_req,
  input wire logic [21:0] flash_rd_addr,
  // array data and activity
  output logic     [7:0]  flash_rd_data,
  output int              n_erase,
  output int              n_prog
);
  timeunit 1ns;
  timeprecision 1ns;
  assign flash_rd_data = flash_rd_addr[7:0] ^ 8'h5A;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      n_erase <= 0;
      n_prog  <= 0;
    end else begin
      n_erase <= n_erase + int'(flash_erase_req);
      n_prog  <= n_prog + int'(flash_prog_req);
    end
  end
endmodule // fsps_flash_model

// ---- bench/flash_self_program_sequencer_tb.sv ----
// testbench: ahb-lite register tasks driving refusal, erase, fill, write, table read
// assumes the sequencer and flash model from this tree, cycle counts shortened to 20
`include "fsps_consts.vh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module flash_self_program_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [7:0]  haddr = 0;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 0;
  logic [31:0] hwdata = 0, q;
  wire         hready, hreadyout, hresp, core_stall, flash_erase_req, flash_prog_req;
  wire [31:0]  hrdata;
  wire [11:0]  flash_block;
  wire [5:0]   flash_chunk;
  wire [511:0] flash_prog_data;
  wire [7:0]   flash_rd_data;
  wire [21:0]  flash_rd_addr;
  int          n_erase, n_prog, fail_count = 0, n_checks = 0;
  assign hready = hreadyout;
  always #50 hclk = ~hclk;
  fsps_sequencer #(.ERASE_CYCLES(20), .WRITE_CYCLES(20)) dut (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .core_stall,
    .flash_erase_req, .flash_prog_req, .flash_block, .flash_chunk, .flash_prog_data,
    .flash_rd_data, .flash_rd_addr);
  fsps_flash_model u_flash (.hclk, .hresetn, .flash_erase_req, .flash_prog_req,
    .flash_rd_addr, .flash_rd_data, .n_erase, .n_prog);
  function automatic logic [7:0] pat(input int i);
    pat = 8'(i * 37 + 17);
  endfunction
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin fail_count++; wrap_up; end
  endtask
  // ends half a cycle on, so checks after a call see settled outputs
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= a; hsize <= 3'h2;
    wait_rdy;
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    wait_rdy;
    q = hrdata;
    @(negedge hclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d); bus(1'b1, a, d); endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK("register", e, q)
  endtask
  // keys then start; any write in between would break the unlock
  task automatic start(input logic [31:0] c);
    wr(`FSPS_OFF_KEY, 32'h55); wr(`FSPS_OFF_KEY, 32'hAA); wr(`FSPS_OFF_CTRL, c);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (core_stall !== 1'b0 && n < 100) begin @(posedge hclk); n++; end
    if (core_stall !== 1'b0) begin fail_count++; wrap_up; end
  endtask
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(`FSPS_OFF_CTRL, 32'h00);
    rdc(`FSPS_OFF_KEY, 32'h00);
    wr(`FSPS_OFF_CTRL, 32'h04); wr(`FSPS_OFF_CTRL, 32'h06);
    `CHK("stall", 1'b0, core_stall)
    rdc(`FSPS_OFF_CTRL, 32'h0C);
    wr(`FSPS_OFF_KEY, 32'hAA); wr(`FSPS_OFF_KEY, 32'h55); wr(`FSPS_OFF_CTRL, 32'h06);
    `CHK("stall", 1'b0, core_stall)
    wr(`FSPS_OFF_KEY, 32'h55); wr(`FSPS_OFF_TLAT, 32'h0);
    wr(`FSPS_OFF_KEY, 32'hAA); wr(`FSPS_OFF_CTRL, 32'h06);
    `CHK("stall", 1'b0, core_stall)
    wr(`FSPS_OFF_CTRL, 32'h00); start(32'h02);
    `CHK("stall", 1'b0, core_stall)
    rdc(`FSPS_OFF_CTRL, 32'h08);
    $display("test refusals done");
    wr(`FSPS_OFF_TPTR, 32'h123456); wr(`FSPS_OFF_CTRL, 32'h14);
    start(32'h16);
    `CHK("stall", 1'b1, core_stall)
    `CHK("block", 12'h48D, flash_block)
    wait_idle;
    rdc(`FSPS_OFF_CTRL, 32'h04);
    `CHK("erases", 1, n_erase)
    $display("test erase done");
    wr(`FSPS_OFF_TPTR, 32'h0007FF);
    for (int i = 0; i < 64; i++) begin
      wr(`FSPS_OFF_TLAT, 32'(pat(i))); wr(`FSPS_OFF_TCMD, 32'h0D);
    end
    `CHK("writes", 0, n_prog)
    `CHK("pointer", 22'h00083F, flash_rd_addr)
    for (int i = 0; i < 64; i++) `CHK("holding", pat(i), flash_prog_data[8*i+:8])
    rdc(8'(`FSPS_OFF_HOLD + 20), 32'(pat(5)));
    $display("test fill done");
    start(32'h06);
    `CHK("stall", 1'b1, core_stall)
    `CHK("block", 12'h002, flash_block)
    `CHK("chunk", 6'h00, flash_chunk)
    wait_idle;
    `CHK("writes", 1, n_prog)
    rdc(`FSPS_OFF_CTRL, 32'h04);
    `CHK("holding", pat(63), flash_prog_data[511:504])
    wr(`FSPS_OFF_CTRL, 32'h00);
    wr(`FSPS_OFF_TCMD, 32'h02); rdc(`FSPS_OFF_TLAT, 32'h65);
    for (int i = 0; i < 64; i++) begin
      wr(`FSPS_OFF_TLAT, 32'(pat(i + 64))); wr(`FSPS_OFF_TCMD, 32'h0D);
    end
    wr(`FSPS_OFF_CTRL, 32'h04); start(32'h06);
    `CHK("block", 12'h002, flash_block)
    `CHK("chunk", 6'h04, flash_chunk)
    wait_idle;
    `CHK("writes", 2, n_prog)
    `CHK("hresp", 1'b0, hresp)
    start(32'h06);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(`FSPS_OFF_CTRL, 32'h08);
    `CHK("stall", 1'b0, core_stall)
    $display("test write done");
    wrap_up;
  end
endmodule // flash_self_program_sequencer_tb
